/* File: hdl/cbf_pkg.sv */
// Shared constants, types and the checksum step for the command block framer.
// Assumes a 100 MHz host clock and a link clock divided from it by the host.
package cbf_pkg;
   typedef logic [7:0] cbf_byte_t;
   typedef logic [6:0] cbf_len_t;
   typedef logic [15:0] cbf_crc_t;

   localparam cbf_len_t BLK_MIN = 7'h04;
   localparam cbf_len_t BLK_MAX = 7'h54;
   localparam cbf_len_t FRAME_OVH = 7'h03;
   localparam cbf_len_t CMD_MIN = 7'h07;
   localparam cbf_len_t PKT_MIN = 7'h04;
   localparam cbf_len_t PKT_MAX = 7'h51;
   localparam int unsigned PKT_DEPTH = 81;

   localparam cbf_len_t POS_OPCODE = 7'h01;
   localparam cbf_len_t POS_FIRST = 7'h02;
   localparam cbf_len_t POS_SECOND_LO = 7'h03;
   localparam cbf_len_t POS_SECOND_HI = 7'h04;

   localparam cbf_byte_t ST_OK = 8'h00;
   localparam cbf_byte_t ST_MISCOMPARE = 8'h01;
   localparam cbf_byte_t ST_PARSE = 8'h03;
   localparam cbf_byte_t ST_EXEC = 8'h0F;
   localparam cbf_byte_t ST_WAKE = 8'h11;
   localparam cbf_byte_t ST_COMM = 8'hFF;

   localparam cbf_crc_t CRC_POLY = 16'h8005;
   localparam cbf_crc_t CRC_INIT = 16'h0000;

   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned LINK_DIV = 8;
   localparam int unsigned LINK_PERIOD_NS = CLK_PERIOD_NS * LINK_DIV;
   localparam logic [2:0] LINK_DIV_LAST = 3'(LINK_DIV - 1);
   localparam logic [2:0] LINK_DIV_HALF = 3'(LINK_DIV / 2);
   localparam logic [1:0] LINK_RST_TICKS = 2'h2;
   localparam logic [1:0] RETRY_MAX = 2'h3;

   localparam int unsigned IO_TIMEOUT_MS = 65;
   localparam int unsigned IO_TIMEOUT_CYC = IO_TIMEOUT_MS * 1000000 / LINK_PERIOD_NS;
   localparam int unsigned WATCHDOG_MS = 1500;
   localparam int unsigned WATCHDOG_CYC = WATCHDOG_MS * 1000000 / LINK_PERIOD_NS;

   // Bits enter LSB first, matching their order on the serial wire
   function automatic cbf_crc_t cbf_crc_byte(input cbf_crc_t crc, input cbf_byte_t b);
      cbf_crc_t c;
      c = crc;
      for (int i = 0; i < 8; i++) begin
         c = (b[i] ^ c[15]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
      end
      return c;
   endfunction : cbf_crc_byte
endpackage : cbf_pkg

/* File: hdl/cbf_link_if.sv */
// Byte-level link between the framer device and its host.
// The host makes linkClk and launches its signals half a link period before each rise.
`timescale 1ns/1ns
`default_nettype none
interface cbf_link_if;
   logic linkClk;
   logic linkRst;
   logic wireMode;
   logic hostValid;
   logic [7:0] hostData;
   logic hostRead;
   logic hostWake;
   logic hostBreak;
   logic devValid;
   logic devNack;
   logic [7:0] devData;

   modport dev (
      input linkClk, linkRst, wireMode, hostValid, hostData, hostRead, hostWake, hostBreak,
      output devValid, devNack, devData
   );
   modport host (
      output linkClk, linkRst, wireMode, hostValid, hostData, hostRead, hostWake, hostBreak,
      input devValid, devNack, devData
   );
endinterface : cbf_link_if
`default_nettype wire

/* File: hdl/cbf_device.sv */
// Device end: receives and checks command blocks, hands them to an executor,
// and serves framed response blocks from one output buffer.
// Runs wholly on the link clock; the executor side shares that clock.
`timescale 1ns/1ns
`default_nettype none
module cbf_device #(
   parameter int unsigned TIMEOUT_CYCLES = cbf_pkg::IO_TIMEOUT_CYC,
   parameter int unsigned WATCHDOG_CYCLES = cbf_pkg::WATCHDOG_CYC
) (
   // Link
   cbf_link_if.dev link,
   // Received packet bytes
   output logic rxValid,
   output cbf_pkg::cbf_len_t rxIdx,
   output cbf_pkg::cbf_byte_t rxData,
   // Command handed to the executor
   output logic cmdValid,
   output cbf_pkg::cbf_len_t cmdCount,
   output cbf_pkg::cbf_byte_t cmdOpcode,
   output cbf_pkg::cbf_byte_t firstParameter,
   output logic [15:0] secondParameter,
   // Executor results
   input wire logic resWe,
   input wire cbf_pkg::cbf_len_t resIdx,
   input wire cbf_pkg::cbf_byte_t resData,
   input wire logic doneValid,
   input wire cbf_pkg::cbf_len_t doneLen,
   input wire cbf_pkg::cbf_byte_t doneCode,
   // State
   output logic busy,
   output logic asleep
);
   import cbf_pkg::*;

   typedef enum logic [3:0] {
      D_IDLE = 4'b0001,
      D_RECV = 4'b0010,
      D_BUSY = 4'b0100,
      D_SLEEP = 4'b1000
   } cbf_dstate_e;

   cbf_dstate_e stQ, stD;
   cbf_len_t cntQ, posQ, pktLenQ, rdPosQ;
   cbf_crc_t rxCrcQ, txCrcQ;
   cbf_byte_t crcLoQ;
   logic [31:0] idleQ;
   cbf_byte_t outBuf [PKT_DEPTH];
   logic devValidQ, devNackQ;
   cbf_byte_t devDataQ;

   wire rst = link.linkRst;
   wire cbf_byte_t inByte = link.hostData;
   wire inRange = (inByte[6:0] >= BLK_MIN) && (inByte[6:0] <= BLK_MAX) && !inByte[7];
   wire startBlk = (stQ == D_IDLE) && link.hostValid && inRange;
   // Out-of-range count cannot be framed; answer it as a link fault
   wire badFirst = (stQ == D_IDLE) && link.hostValid && !inRange;
   wire rxByte = (stQ == D_RECV) && link.hostValid;
   wire lastByte = rxByte && (posQ == cntQ - 7'h01);
   wire isPkt = rxByte && (posQ < cntQ - 7'h02);
   wire isCrcLo = rxByte && (posQ == cntQ - 7'h02);
   wire crcOk = ({inByte, crcLoQ} == rxCrcQ);
   wire shortCmd = (cntQ < CMD_MIN);
   wire brk = (stQ == D_RECV) && link.wireMode && link.hostBreak;
   wire [31:0] tmoLimit = link.wireMode ? WATCHDOG_CYCLES : TIMEOUT_CYCLES;
   wire tmo = (stQ == D_RECV) && (idleQ >= tmoLimit - 32'h1);
   wire wakeUp = (stQ == D_SLEEP) && link.hostWake;
   wire done = (stQ == D_BUSY) && doneValid;
   wire exec = lastByte && crcOk && !shortCmd;
   wire commErr = badFirst || (lastByte && !crcOk);
   wire parseErr = lastByte && crcOk && shortCmd;
   wire loadCode = commErr || parseErr || wakeUp || (done && (doneLen == 7'h00));

   // CRC failure is tested first so it masks any parse result
   wire cbf_byte_t codeSel = commErr ? ST_COMM :
                             parseErr ? ST_PARSE :
                             wakeUp ? ST_WAKE :
                             doneCode;

   wire resWr = (stQ == D_BUSY) && resWe && (resIdx < PKT_MAX);
   wire bufWe = loadCode || resWr;
   wire cbf_len_t bufIdx = loadCode ? 7'h00 : resIdx;
   wire cbf_byte_t bufData = loadCode ? codeSel : resData;
   wire newOut = loadCode || done;
   wire cbf_len_t doneLenC = (doneLen > PKT_MAX) ? PKT_MAX : doneLen;

   wire rdOk = (stQ == D_IDLE) && link.hostRead;
   wire rdRefuse = link.hostRead && ((stQ == D_RECV) || (stQ == D_BUSY));
   wire lastRd = (rdPosQ == pktLenQ + 7'h02);
   wire cbf_len_t rdBufIdx = rdPosQ - 7'h01;
   wire cbf_byte_t txByte = (rdPosQ == 7'h00) ? {1'b0, pktLenQ + FRAME_OVH} :
                            (rdPosQ <= pktLenQ) ? outBuf[rdBufIdx] :
                            (rdPosQ == pktLenQ + 7'h01) ? txCrcQ[7:0] :
                            txCrcQ[15:8];
   wire cbf_crc_t txCrcBase = (rdPosQ == 7'h00) ? CRC_INIT : txCrcQ;

   always_comb begin
      stD = stQ;
      case (stQ)
         D_IDLE: begin
            if (startBlk) begin
               stD = D_RECV;
            end
         end
         D_RECV: begin
            if (lastByte) begin
               stD = exec ? D_BUSY : D_IDLE;
            end else if (brk) begin
               stD = D_IDLE;
            end else if (tmo) begin
               stD = D_SLEEP;
            end
         end
         D_BUSY: begin
            // Link inputs other than reads are not looked at here
            if (done) begin
               stD = D_IDLE;
            end
         end
         D_SLEEP: begin
            if (wakeUp) begin
               stD = D_IDLE;
            end
         end
         default: begin
            stD = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         stQ <= D_IDLE;
         busy <= 1'b0;
         asleep <= 1'b0;
      end else begin
         stQ <= stD;
         busy <= (stD == D_BUSY);
         asleep <= (stD == D_SLEEP);
      end
   end

   // Input framing
   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         cntQ <= 7'h00;
         posQ <= 7'h00;
         rxCrcQ <= CRC_INIT;
         crcLoQ <= 8'h00;
      end else if (startBlk) begin
         cntQ <= inByte[6:0];
         posQ <= 7'h01;
         rxCrcQ <= cbf_crc_byte(CRC_INIT, inByte);
      end else if (rxByte) begin
         posQ <= posQ + 7'h01;
         if (isPkt) begin
            rxCrcQ <= cbf_crc_byte(rxCrcQ, inByte);
         end
         if (isCrcLo) begin
            crcLoQ <= inByte;
         end
      end
   end

   always_ff @(posedge link.linkClk) begin
      if (rst || startBlk || rxByte || (stQ != D_RECV)) begin
         idleQ <= 32'h0;
      end else begin
         idleQ <= idleQ + 32'h1;
      end
   end

   // Executor hand-off
   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         rxValid <= 1'b0;
         rxIdx <= 7'h00;
         rxData <= 8'h00;
         cmdValid <= 1'b0;
         cmdCount <= 7'h00;
         cmdOpcode <= 8'h00;
         firstParameter <= 8'h00;
         secondParameter <= 16'h0000;
      end else begin
         // Executor sees every packet byte and the count; surplus is its to drop
         rxValid <= isPkt;
         rxIdx <= posQ - 7'h01;
         rxData <= inByte;
         cmdValid <= exec;
         cmdCount <= cntQ;
         if (isPkt && (posQ == POS_OPCODE)) begin
            cmdOpcode <= inByte;
         end
         if (isPkt && (posQ == POS_FIRST)) begin
            firstParameter <= inByte;
         end
         if (isPkt && (posQ == POS_SECOND_LO)) begin
            secondParameter[7:0] <= inByte;
         end
         if (isPkt && (posQ == POS_SECOND_HI)) begin
            secondParameter[15:8] <= inByte;
         end
      end
   end

   // Output buffer: storage only, so no reset except the wake code
   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         outBuf[0] <= ST_WAKE;
      end else if (bufWe) begin
         outBuf[bufIdx] <= bufData;
      end
   end

   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         pktLenQ <= 7'h01;
         rdPosQ <= 7'h00;
         txCrcQ <= CRC_INIT;
      end else if (newOut) begin
         pktLenQ <= loadCode ? 7'h01 : doneLenC;
         rdPosQ <= 7'h00;
      end else if (rdOk) begin
         rdPosQ <= lastRd ? 7'h00 : rdPosQ + 7'h01;
         if (rdPosQ <= pktLenQ) begin
            txCrcQ <= cbf_crc_byte(txCrcBase, txByte);
         end
      end
   end

   always_ff @(posedge link.linkClk) begin
      if (rst) begin
         devValidQ <= 1'b0;
         devNackQ <= 1'b0;
         devDataQ <= 8'h00;
      end else begin
         devValidQ <= rdOk;
         devNackQ <= rdRefuse;
         if (rdOk) begin
            devDataQ <= txByte;
         end
      end
   end

   assign link.devValid = devValidQ;
   assign link.devNack = devNackQ;
   assign link.devData = devDataQ;
endmodule : cbf_device
`default_nettype wire

/* File: hdl/cbf_host.sv */
// Host end: frames a stored packet, sends it, polls for the response block,
// checks its CRC and resends after a communication error.
// Makes the link clock by dividing clk; device replies are synchronised back.
`timescale 1ns/1ns
`default_nettype none
module cbf_host (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Link
   cbf_link_if.host link,
   // Packet loading and start
   input wire logic modeI2c,
   input wire logic wrEn,
   input wire cbf_pkg::cbf_len_t wrIdx,
   input wire cbf_pkg::cbf_byte_t wrData,
   input wire logic goReq,
   input wire cbf_pkg::cbf_len_t goLen,
   output logic goReady,
   // Response
   output logic rspValid,
   output cbf_pkg::cbf_byte_t rspData,
   output logic rspDone,
   output cbf_pkg::cbf_byte_t rspCode,
   output logic rspCrcOk
);
   import cbf_pkg::*;

   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_WAKE = 4'b0010,
      H_SEND = 4'b0100,
      H_POLL = 4'b1000
   } cbf_hstate_e;

   cbf_hstate_e stQ;
   logic [2:0] divQ;
   logic [1:0] rstTickQ, retryQ;
   logic clkQ, lrstQ, hValidQ, hReadQ, hWakeQ, hBreakQ, modeQ, armQ, goPendQ;
   cbf_byte_t hDataQ;
   cbf_len_t lenQ, posQ, rcntQ, rposQ;
   cbf_crc_t txCrcQ, rxCrcQ;
   cbf_byte_t rxLoQ;
   cbf_byte_t pkt [PKT_DEPTH];
   logic v1Q, v2Q;
   cbf_byte_t d1Q, d2Q;

   wire tick = (divQ == LINK_DIV_LAST);
   wire [2:0] divD = tick ? 3'h0 : divQ + 3'h1;
   wire goOk = goReq && goReady && (goLen >= PKT_MIN) && (goLen <= PKT_MAX);
   wire sendTick = tick && ((stQ == H_WAKE) || (stQ == H_SEND));
   wire sendLast = (posQ == lenQ + 7'h02);
   wire cbf_len_t pktIdx = posQ - 7'h01;
   wire cbf_byte_t sndByte = (posQ == 7'h00) ? {1'b0, lenQ + FRAME_OVH} :
                             (posQ <= lenQ) ? pkt[pktIdx] :
                             (posQ == lenQ + 7'h01) ? txCrcQ[7:0] :
                             txCrcQ[15:8];
   wire cbf_crc_t txBase = (posQ == 7'h00) ? CRC_INIT : txCrcQ;
   wire pollTick = tick && (stQ == H_POLL);
   wire gotV = pollTick && armQ && v2Q;
   wire rdLast = gotV && (rposQ != 7'h00) && (rposQ == rcntQ - 7'h01);
   wire rdPkt = gotV && (rposQ != 7'h00) && (rposQ < rcntQ - 7'h02);
   wire cbf_crc_t rxBase = (rposQ == 7'h00) ? CRC_INIT : rxCrcQ;
   wire crcGood = ({d2Q, rxLoQ} == rxCrcQ);
   // Only a clean four-byte link-error answer is worth a blind resend
   wire resend = rdLast && crcGood && (rcntQ == BLK_MIN) && (rspCode == ST_COMM) &&
                 (retryQ != RETRY_MAX);

   // Link clock divider is held at zero in sys_rst; link reset stays up two ticks after so the device sees it
   always_ff @(posedge clk) begin
      divQ <= sys_rst ? 3'h0 : divD;
      clkQ <= sys_rst ? 1'b0 : (divD >= LINK_DIV_HALF);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lrstQ <= 1'b1;
         rstTickQ <= 2'h0;
      end else if (tick && lrstQ) begin
         rstTickQ <= rstTickQ + 2'h1;
         lrstQ <= (rstTickQ + 2'h1 != LINK_RST_TICKS);
      end
   end

   // Device outputs are on another clock; two stages before use
   always_ff @(posedge clk) begin
      v1Q <= sys_rst ? 1'b0 : link.devValid;
      v2Q <= sys_rst ? 1'b0 : v1Q;
      d1Q <= sys_rst ? 8'h00 : link.devData;
      d2Q <= sys_rst ? 8'h00 : d1Q;
   end

   always_ff @(posedge clk) begin
      if (wrEn && (wrIdx < PKT_MAX)) begin
         pkt[wrIdx] <= wrData;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stQ <= H_IDLE;
         goPendQ <= 1'b0;
         goReady <= 1'b0;
         lenQ <= PKT_MIN;
         posQ <= 7'h00;
         retryQ <= 2'h0;
         modeQ <= 1'b0;
         hValidQ <= 1'b0;
         hDataQ <= 8'h00;
         hReadQ <= 1'b0;
         hWakeQ <= 1'b0;
         hBreakQ <= 1'b0;
         armQ <= 1'b0;
         txCrcQ <= CRC_INIT;
      end else begin
         goReady <= (stQ == H_IDLE) && !goPendQ && !goOk && !lrstQ;
         modeQ <= modeI2c;
         if (goOk) begin
            goPendQ <= 1'b1;
            lenQ <= goLen;
            retryQ <= 2'h0;
         end
         if (tick && (stQ == H_IDLE) && goPendQ) begin
            stQ <= H_WAKE;
            goPendQ <= 1'b0;
            posQ <= 7'h00;
            hWakeQ <= 1'b1;
            hBreakQ <= modeQ;
         end
         if (sendTick) begin
            hWakeQ <= 1'b0;
            hBreakQ <= 1'b0;
            hValidQ <= 1'b1;
            hDataQ <= sndByte;
            posQ <= posQ + 7'h01;
            if (posQ <= lenQ) begin
               txCrcQ <= cbf_crc_byte(txBase, sndByte);
            end
            stQ <= sendLast ? H_POLL : H_SEND;
            armQ <= 1'b0;
         end
         if (pollTick) begin
            hValidQ <= 1'b0;
            hReadQ <= !rdLast;
            armQ <= !rdLast;
            if (rdLast) begin
               stQ <= resend ? H_WAKE : H_IDLE;
               posQ <= 7'h00;
               hWakeQ <= resend;
               hBreakQ <= resend && modeQ;
               retryQ <= resend ? retryQ + 2'h1 : retryQ;
            end
         end
      end
   end

   // Response assembly
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rcntQ <= 7'h00;
         rposQ <= 7'h00;
         rxCrcQ <= CRC_INIT;
         rxLoQ <= 8'h00;
         rspValid <= 1'b0;
         rspData <= 8'h00;
         rspDone <= 1'b0;
         rspCode <= 8'h00;
         rspCrcOk <= 1'b0;
      end else begin
         rspValid <= rdPkt;
         rspDone <= rdLast;
         if (sendTick) begin
            rposQ <= 7'h00;
         end
         if (gotV) begin
            rposQ <= rdLast ? 7'h00 : rposQ + 7'h01;
            if ((rposQ == 7'h00) || rdPkt) begin
               rxCrcQ <= cbf_crc_byte(rxBase, d2Q);
            end
            if (rposQ == 7'h00) begin
               rcntQ <= d2Q[6:0];
            end
            if (rdPkt) begin
               rspData <= d2Q;
            end
            if (rdPkt && (rposQ == 7'h01)) begin
               rspCode <= d2Q;
            end
            if (!rdLast && !rdPkt && (rposQ != 7'h00)) begin
               rxLoQ <= d2Q;
            end
            if (rdLast) begin
               rspCrcOk <= crcGood;
            end
         end
      end
   end

   assign link.linkClk = clkQ;
   assign link.linkRst = lrstQ;
   assign link.wireMode = modeQ;
   assign link.hostValid = hValidQ;
   assign link.hostData = hDataQ;
   assign link.hostRead = hReadQ;
   assign link.hostWake = hWakeQ;
   assign link.hostBreak = hBreakQ;
endmodule : cbf_host
`default_nettype wire

/* File: testbench/cbf_link_properties.sv */
// Checker for the byte link between host and device ends.
// Assumes it sits beside the interface and sees every link signal.
`timescale 1ns/1ns
`default_nettype none
module cbf_link_properties (
   // Link clock and reset
   input wire logic linkClk,
   input wire logic linkRst,
   // Host to device
   input wire logic wireMode,
   input wire logic hostValid,
   input wire logic [7:0] hostData,
   input wire logic hostRead,
   input wire logic hostWake,
   input wire logic hostBreak,
   // Device to host
   input wire logic devValid,
   input wire logic devNack,
   input wire logic [7:0] devData
);
   default clocking cb @(posedge linkClk);
   endclocking
   default disable iff (linkRst);
   logic [6:0] hRem_q;
   logic [6:0] dRem_q;
   logic [15:0] hCrc_q;
   logic [15:0] dCrc_q;
   wire hFirst = hRem_q == 7'h00;
   wire dFirst = dRem_q == 7'h00;
   wire lastByte = hostValid && hRem_q == 7'h01;
   // Own copy of the checksum step, kept apart from the design's
   function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (b[i] ^ r[15]) ? ({r[14:0], 1'b0} ^ 16'h8005) : {r[14:0], 1'b0};
      end
      return r;
   endfunction : step
   always_ff @(posedge linkClk) begin
      if (linkRst) begin
         hRem_q <= 7'h00;
         dRem_q <= 7'h00;
         hCrc_q <= 16'h0000;
         dCrc_q <= 16'h0000;
      end else begin
         if (hostValid) begin
            hRem_q <= hFirst ? 7'(hostData - 8'h01) : hRem_q - 7'h01;
            hCrc_q <= hFirst ? step(16'h0000, hostData) :
               (hRem_q > 7'h02) ? step(hCrc_q, hostData) : hCrc_q;
         end
         if (devValid) begin
            dRem_q <= dFirst ? 7'(devData - 8'h01) : dRem_q - 7'h01;
            dCrc_q <= dFirst ? step(16'h0000, devData) :
               (dRem_q > 7'h02) ? step(dCrc_q, devData) : dCrc_q;
         end
      end
   end
   chk_no_dual_answer: assert property (!(devValid && devNack))
      else $error("device answered and refused at once");
   chk_answer_needs_read: assert property ((devValid || devNack) |-> $past(hostRead))
      else $error("device answer without a read");
   chk_read_gets_reply: assert property (hostRead |=> (devValid ^ devNack))
      else $error("read left without exactly one reply");
   chk_count_range: assert property (hostValid && hFirst |-> hostData inside {[8'h07:8'h54]})
      else $error("command count byte out of range");
   chk_cmd_crc_lo: assert property (hostValid && hRem_q == 7'h02 |-> hostData == hCrc_q[7:0])
      else $error("command checksum low byte wrong");
   chk_cmd_crc_hi: assert property (lastByte |-> hostData == hCrc_q[15:8])
      else $error("command checksum high byte wrong");
   chk_busy_refuses: assert property (lastByte ##1 hostRead |=> devNack)
      else $error("read served right after a block");
   chk_rsp_count: assert property (devValid && dFirst |-> devData inside {[8'h04:8'h54]})
      else $error("response count byte out of range");
   chk_rsp_crc: assert property (devValid && dRem_q inside {7'h01, 7'h02} |->
      devData == (dRem_q == 7'h02 ? dCrc_q[7:0] : dCrc_q[15:8]))
      else $error("response checksum wrong");
   chk_break_i2c: assert property (hostBreak |-> wireMode)
      else $error("break sent in single-wire mode");
   cover property (lastByte);
   cover property (devNack ##1 devValid);
   cover property (hostBreak);
endmodule : cbf_link_properties
`default_nettype wire

/* File: testbench/command_block_framer_tb_top.sv */
// Testbench: host and device ends joined by the link; the bench plays user and executor.
// Assumes the host derives the link clock from clk.
`timescale 1ns/1ns
`default_nettype none
module command_block_framer_tb_top;
   import cbf_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic modeI2c = 1'b0;
   logic wrEn = 1'b0;
   cbf_len_t wrIdx = 7'h00;
   cbf_byte_t wrData = 8'h00;
   logic goReq = 1'b0;
   cbf_len_t goLen = 7'h00;
   logic goReady, rspValid, rspDone, rspCrcOk, cmdValid, busy, rxValid;
   cbf_byte_t rspData, rspCode, cmdOpcode, firstParameter, rxData;
   cbf_len_t cmdCount, rxIdx;
   logic [15:0] secondParameter;
   logic resWe = 1'b0;
   cbf_len_t resIdx = 7'h00;
   cbf_byte_t resData = 8'h00;
   logic doneValid = 1'b0;
   cbf_len_t doneLen = 7'h00;
   cbf_byte_t doneCode = 8'h00;
   cbf_byte_t rC = 8'h00;
   cbf_byte_t pkt [0:80];
   cbf_byte_t rb [0:7];
   cbf_byte_t got [0:1023];
   int gotN = 0, nCmd = 0, exCnt = 0, pLen = 0, rN = 0, c0 = 0;
   int nMismatch = 0, testsRun = 0;
   cbf_link_if link ();
   cbf_host cbf_host_i (.clk(clk), .sys_rst(sys_rst), .link(link), .modeI2c(modeI2c),
      .wrEn(wrEn), .wrIdx(wrIdx), .wrData(wrData), .goReq(goReq), .goLen(goLen),
      .goReady(goReady), .rspValid(rspValid), .rspData(rspData), .rspDone(rspDone),
      .rspCode(rspCode), .rspCrcOk(rspCrcOk));
   // Short timeouts keep the run brief; no incomplete block is sent anyway
   cbf_device #(.TIMEOUT_CYCLES(50), .WATCHDOG_CYCLES(80)) cbf_device_i (.link(link),
      .rxValid(rxValid), .rxIdx(rxIdx), .rxData(rxData), .cmdValid(cmdValid),
      .cmdCount(cmdCount),
      .cmdOpcode(cmdOpcode), .firstParameter(firstParameter),
      .secondParameter(secondParameter), .resWe(resWe), .resIdx(resIdx), .resData(resData),
      .doneValid(doneValid), .doneLen(doneLen), .doneCode(doneCode), .busy(busy),
      .asleep());
   cbf_link_properties cbf_link_properties_i (.linkClk(link.linkClk),
      .linkRst(link.linkRst), .wireMode(link.wireMode), .hostValid(link.hostValid),
      .hostData(link.hostData), .hostRead(link.hostRead), .hostWake(link.hostWake),
      .hostBreak(link.hostBreak), .devValid(link.devValid), .devNack(link.devNack),
      .devData(link.devData));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      if (nMismatch == 0 && testsRun > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nMismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   function automatic cbf_byte_t expByte(input int i);
      return (rN == 0) ? rC : rb[i];
   endfunction : expByte
   always @(posedge clk) begin
      if (rspValid === 1'b1) begin
         got[gotN] <= rspData;
         gotN <= gotN + 1;
      end
   end
   // Executor: checks the handed-over command, then answers after a pause
   always @(posedge link.linkClk) begin
      resWe <= 1'b0;
      doneValid <= 1'b0;
      if (rxValid === 1'b1) begin
         chk(rxData, pkt[rxIdx]);
      end
      if (cmdValid === 1'b1) begin
         exCnt <= 1;
         nCmd <= nCmd + 1;
         chk(cmdCount, 16'(pLen + 3));
         chk(cmdOpcode, pkt[0]);
         chk(firstParameter, pkt[1]);
         chk(secondParameter, {pkt[3], pkt[2]});
         chk(busy, 1'b1);
      end else if (exCnt > 0) begin
         exCnt <= (exCnt == rN + 6) ? 0 : exCnt + 1;
         resWe <= exCnt <= rN;
         resIdx <= 7'(exCnt - 1);
         resData <= rb[(exCnt - 1) % 8];
         doneValid <= exCnt == rN + 6;
         doneLen <= 7'(rN);
         doneCode <= rC;
      end
   end
   task automatic waitReady();
      int k;
      k = 0;
      while (goReady !== 1'b1 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      if (goReady !== 1'b1) begin
         nMismatch++;
         stop_test();
      end
      c0 = nCmd;
   endtask : waitReady
   task automatic run(input int len, input int nres, input cbf_byte_t code, input int ncmd,
      input logic mode);
      int k, n;
      pLen = len;
      rN = nres;
      rC = code;
      for (int i = 0; i < 8; i++) begin
         rb[i] = 8'($urandom);
      end
      modeI2c <= mode;
      for (int i = 0; i < len; i++) begin
         pkt[i] = 8'($urandom);
         wrEn <= 1'b1;
         wrIdx <= 7'(i);
         wrData <= pkt[i];
         @(posedge clk);
      end
      wrEn <= 1'b0;
      waitReady();
      goReq <= 1'b1;
      goLen <= 7'(len);
      @(posedge clk);
      goReq <= 1'b0;
      // Each automatic resend ends in a response of its own; wait for the last one
      k = 0;
      n = 0;
      while (n < ncmd && k < 40000) begin
         @(posedge clk);
         k++;
         if (rspDone === 1'b1) begin
            n++;
         end
      end
      if (n < ncmd) begin
         nMismatch++;
         stop_test();
      end
      chk(rspCrcOk, 1'b1);
      chk(rspCode, expByte(0));
      k = (nres == 0) ? 1 : nres;
      for (int i = 0; i < k; i++) begin
         chk(got[gotN - k + i], expByte(i));
      end
      chk(16'(nCmd - c0), 16'(ncmd));
   endtask : run
   initial begin
      cbf_byte_t codes [3];
      codes = '{ST_MISCOMPARE, ST_EXEC, ST_OK};
      void'($urandom(32'h7247f80f));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      run(4, 0, ST_OK, 1, 1'b0);
      run(81, 3, ST_OK, 1, 1'b1);
      foreach (codes[i]) begin
         run(4 + $urandom % 20, 0, codes[i], 1, 1'(i));
      end
      run(10, 0, ST_COMM, 4, 1'b0);
      repeat (6) begin
         run(4 + $urandom % 78, 1 + $urandom % 8, ST_OK, 1, 1'($urandom));
      end
      waitReady();
      goReq <= 1'b1;
      goLen <= 7'h03;
      @(posedge clk);
      goReq <= 1'b0;
      repeat (400) @(posedge clk);
      chk(16'(nCmd - c0), 16'h0000);
      stop_test();
   end
endmodule : command_block_framer_tb_top
`default_nettype wire
